// ===== testbench/dlct_cpu_model.sv
`timescale 1ns/100ps
module dlct_cpu_model
  import dlct_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ack_en,
  input  wire logic [3:0] flags,
  output logic      [3:0] acks
);
  ////////////////////////////////////////////////////////////////////////////
  // Vectoring: one ack pulse per pending flag, two samples after it rises
  logic [3:0] seen_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen_reg <= 4'h0;
      acks     <= 4'h0;
    end else begin
      seen_reg <= flags;
      acks     <= ack_en ? (flags & seen_reg & ~acks) : 4'h0;
    end
  end
endmodule

// ===== testbench/dual_legacy_counter_timer_bench.sv
`timescale 1ns/100ps
module dual_legacy_counter_timer_bench
  import dlct_pkg::*;
;
  localparam logic [7:0] TL_INIT [3] = '{8'h1f, 8'hfe, 8'hff};
  localparam logic [7:0] TH_INIT [3] = '{8'hff, 8'hff, 8'h80};
  localparam logic [7:0] TL_EXP  [3] = '{8'h00, 8'h01, 8'h81};
  localparam logic [7:0] TH_EXP  [3] = '{8'h00, 8'h00, 8'h80};
  localparam int         PULSES  [3] = '{1, 3, 2};
  localparam logic [7:0] CK_VAL  [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04};
  localparam int         DIV_VAL [5] = '{12, 4, 48, 32, 1};

  logic       ref_clk   = 1'b0;
  logic       rst       = 1'b1;
  logic [7:0] sfr_addr  = 8'h00;
  logic       sfr_wr    = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [1:0] ev        = 2'h3;
  logic [1:0] gate_in   = 2'h0;
  logic [1:0] pol       = 2'h3;
  logic [1:0] osc_cnt   = 2'h0;
  logic       t2_split  = 1'b0;
  logic       t3_split  = 1'b0;
  logic       t2x       = 1'b0;
  logic       t3x       = 1'b0;
  logic       ack_en    = 1'b0;
  logic [3:0] flags;
  logic [3:0] acks;
  logic       pulse1;
  dlct_src_t  src [4];
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         pulse_cnt = 0;

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) osc_cnt <= osc_cnt + 2'h1;
  always @(posedge ref_clk) if (pulse1 === 1'b1) pulse_cnt <= pulse_cnt + 1;

  dlct_timers u_dlct_timers (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .sfr_addr         (sfr_addr),
    .sfr_wr           (sfr_wr),
    .sfr_wdata        (sfr_wdata),
    .sfr_rdata        (sfr_rdata),
    .event_pin_0      (ev[0]),
    .event_pin_1      (ev[1]),
    .ext_gate_in_0    (gate_in[0]),
    .ext_gate_in_1    (gate_in[1]),
    .gate_polarity_0  (pol[0]),
    .gate_polarity_1  (pol[1]),
    .ext_osc_clk      (osc_cnt[1]),
    .t2_split         (t2_split),
    .t3_split         (t3_split),
    .t2_extclk_sel    (t2x),
    .t3_extclk_sel    (t3x),
    .ovf_vector_ack_0 (acks[0]),
    .ovf_vector_ack_1 (acks[1]),
    .ext_vector_ack_0 (acks[2]),
    .ext_vector_ack_1 (acks[3]),
    .ovf_flag_0       (flags[0]),
    .ovf_flag_1       (flags[1]),
    .ext_irq_flag_0   (flags[2]),
    .ext_irq_flag_1   (flags[3]),
    .unit1_ovf_pulse  (pulse1),
    .t2_low_src       (src[0]),
    .t2_high_src      (src[1]),
    .t3_low_src       (src[2]),
    .t3_high_src      (src[3])
  );

  dlct_cpu_model u_dlct_cpu_model (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ack_en  (ack_en),
    .flags   (flags),
    .acks    (acks)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    sfr_addr  <= a;
    sfr_wr    <= 1'b1;
    sfr_wdata <= v;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    @(posedge ref_clk);
    #1;
    d = sfr_rdata;
  endtask

  // Pin low and high for at least two cycles each, then let the count land
  task automatic pulse(input int u, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      ev[u] <= 1'b0;
      repeat (2) @(posedge ref_clk);
      ev[u] <= 1'b1;
      repeat (2) @(posedge ref_clk);
    end
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic wait_flag(input int i, input logic lvl);
    for (int k = 0; k < 60 && flags[i] !== lvl; k++) @(posedge ref_clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    dlct_src_t  lo_e;
    dlct_src_t  hi_e;
    int         n0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 8'h88; a < 8'h8f; a++) begin
      rd(a[7:0], d);
      chk("reset value", 8'h00, d);
    end
    wr(8'h90, 8'hff);
    rd(8'h90, d);
    chk("unmapped read", 8'h00, d);
    // Modes 0 to 2 on each unit, counting pin edges across the wrap
    for (int u = 0; u < 2; u++) begin
      for (int m = 0; m < 3; m++) begin
        wr(8'h88, 8'h00);
        wr(8'h89, u ? {2'b01, m[1:0], 4'h0} : {4'h0, 2'b01, m[1:0]});
        wr(8'h8a + u[7:0], TL_INIT[m]);
        wr(8'h8c + u[7:0], TH_INIT[m]);
        wr(8'h88, u ? 8'h40 : 8'h10);
        pulse(u, PULSES[m]);
        rd(8'h8a + u[7:0], d);
        chk("count low", TL_EXP[m], d & (m == 0 ? 8'h1f : 8'hff));
        rd(8'h8c + u[7:0], d);
        chk("count high", TH_EXP[m], d);
        rd(8'h88, d);
        chk("control status", u ? 8'hc0 : 8'h30, d);
        wr(8'h88, 8'h00);
        rd(8'h88, d);
        chk("flag cleared", 8'h00, d);
      end
    end
    wr(8'h89, 8'h05);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    pulse(0, 1);
    chk("overflow flag", 8'h01, {7'h0, flags[0]});
    @(posedge ref_clk);
    ack_en <= 1'b1;
    wait_flag(0, 1'b0);
    chk("flag after vectoring", 8'h00, {7'h0, flags[0]});
    ack_en <= 1'b0;
    // Gate, polarity and the external flag
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h0d);
    wr(8'h8a, 8'h00);
    wr(8'h88, 8'h10);
    pulse(0, 2);
    rd(8'h8a, d);
    chk("gate closed count", 8'h00, d);
    chk("level flag idle", 8'h00, {7'h0, flags[2]});
    @(posedge ref_clk);
    gate_in[0] <= 1'b1;
    pulse(0, 2);
    rd(8'h8a, d);
    chk("gate open count", 8'h02, d);
    chk("level flag active", 8'h01, {7'h0, flags[2]});
    @(posedge ref_clk);
    pol[0] <= 1'b0;
    pulse(0, 1);
    rd(8'h8a, d);
    chk("inverted gate count", 8'h02, d);
    chk("level flag inverted", 8'h00, {7'h0, flags[2]});
    wr(8'h88, 8'h11);
    @(posedge ref_clk);
    gate_in[0] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("edge flag", 8'h01, {7'h0, flags[2]});
    ack_en <= 1'b1;
    wait_flag(2, 1'b0);
    chk("edge flag after vectoring", 8'h00, {7'h0, flags[2]});
    ack_en <= 1'b0;
    wr(8'h88, 8'h01);
    pulse(0, 1);
    rd(8'h88, d);
    chk("control status", 8'h01, d);
    rd(8'h8a, d);
    chk("stopped count", 8'h02, d);
    wr(8'h88, 8'h04);
    gate_in[1] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    gate_in[1] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("edge flag 1", 8'h01, {7'h0, flags[3]});
    // Split mode
    wr(8'h88, 8'h00);
    wr(8'h8b, 8'hff);
    wr(8'h8d, 8'hff);
    wr(8'h8c, 8'hf0);
    wr(8'h8a, 8'h00);
    wr(8'h8e, 8'h0c);
    n0 = pulse_cnt;
    wr(8'h89, 8'h17);
    repeat (20) @(posedge ref_clk);
    chk("unit 1 pulse in split", 8'h01, {7'h0, pulse_cnt > n0});
    chk("unit 1 flag in split", 8'h00, {7'h0, flags[1]});
    rd(8'h8c, d);
    chk("high byte held", 8'hf0, d);
    wr(8'h88, 8'h10);
    pulse(0, 2);
    rd(8'h8a, d);
    chk("split low byte", 8'h02, d);
    wr(8'h89, 8'h37);
    wr(8'h8b, 8'h33);
    repeat (8) @(posedge ref_clk);
    rd(8'h8b, d);
    chk("unit 1 stopped", 8'h33, d);
    wr(8'h88, 8'h50);
    wait_flag(1, 1'b1);
    chk("high byte overflow", 8'h01, {7'h0, flags[1]});
    // Prescaler: ticks in a window of four periods
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h01);
    wr(8'h88, 8'h10);
    for (int i = 0; i < 5; i++) begin
      wr(8'h8e, CK_VAL[i]);
      repeat (DIV_VAL[i]) @(posedge ref_clk);
      rd(8'h8a, n0[7:0]);
      repeat (4 * DIV_VAL[i] - 2) @(posedge ref_clk);
      rd(8'h8a, d);
      chk("ticks per window", 8'h04, d - n0[7:0]);
    end
    // Timer 2 and 3 clock sources
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      t2_split <= i[3];
      t3_split <= i[3];
      t2x      <= i[2];
      t3x      <= i[2];
      wr(8'h8e, {i[1], i[0], i[1], i[0], 4'h0});
      repeat (2) @(posedge ref_clk);
      lo_e = i[0] ? DLCT_SRC_SYS : (i[2] ? DLCT_SRC_EXT8 : DLCT_SRC_DIV12);
      hi_e = !i[3] ? lo_e : (i[1] ? DLCT_SRC_SYS : (i[2] ? DLCT_SRC_EXT8 : DLCT_SRC_DIV12));
      for (int k = 0; k < 4; k++) begin
        chk("clock source", {6'h0, k[0] ? hi_e : lo_e}, {6'h0, src[k]});
      end
    end
    give_verdict();
  end
endmodule

// ===== verilog/dlct_pin_sync.sv
`timescale 1ns/100ps
module dlct_pin_sync
  import dlct_pkg::*;
#(
  parameter int W = PIN_COUNT
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall,
  output logic      [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } dlct_sync_t;

  dlct_sync_t state_reg;
  dlct_sync_t state_next;

  always_comb begin
    state_next.s1 = pin_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // One edge per transition from current vs previous sample
  assign level = state_reg.s2;
  assign fall  = state_reg.s3 & ~state_reg.s2; // RQ22
  assign rise  = ~state_reg.s3 & state_reg.s2;
endmodule

// ===== verilog/dlct_pkg.sv
// Functional notes
// RQ1: Count only when run and gate condition met
// RQ2: Setting run never clears or loads counts
// RQ3: Unit 1 mirrors unit 0 with own bits
// RQ4: 13-bit mode wraps 0x1fff, sets overflow flag
// RQ5: 16-bit mode counts over both bytes
// RQ6: Auto-reload low byte from high on wrap
// RQ7: Split: low byte unit 0, high byte timer
// RQ8: Split high byte overflow sets unit 1 flag
// RQ9: Split: unit 1 no pin, no flag, pulse out
// RQ10: Split: unit 1 stops only in mode 3
// RQ11: Overflow flags cleared by software or vectoring
// RQ12: External flag edge/level, auto-clear edge only
// RQ13: Type bit 0 level, 1 edge
// RQ14: Two-bit mode fields, unit 1 upper nibble
// RQ15: Counter select counts falling pin edges
// RQ16: Clock select: prescaled or system clock
// RQ17: Prescale 12, 4, 48, or external/8
// RQ18: External clock resynchronised before use
// RQ19: Timer 2/3 high clock selects in split
// RQ20: Timer 2/3 low clock selects whole timer
// RQ21: Pin levels held two clocks, quarter rate
// RQ22: Two-stage sync, edge from sample compare
package dlct_pkg;

  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h88;
  localparam logic [7:0] ADDR_MODE_SEL    = 8'h89;
  localparam logic [7:0] ADDR_U0_LO       = 8'h8a;
  localparam logic [7:0] ADDR_U1_LO       = 8'h8b;
  localparam logic [7:0] ADDR_U0_HI       = 8'h8c;
  localparam logic [7:0] ADDR_U1_HI       = 8'h8d;
  localparam logic [7:0] ADDR_CLK_SEL     = 8'h8e;
  localparam logic [7:0] RST_BYTE         = 8'h00;

  // Control/status byte
  localparam int CS_OVF1 = 7;
  localparam int CS_RUN1 = 6;
  localparam int CS_OVF0 = 5;
  localparam int CS_RUN0 = 4;
  localparam int CS_XF1  = 3;
  localparam int CS_XT1  = 2;
  localparam int CS_XF0  = 1;
  localparam int CS_XT0  = 0;
  // Mode select byte
  localparam int MS_GATE_EN_1 = 7;
  localparam int MS_CNT1  = 6;
  localparam int MS_MODE1 = 4;
  localparam int MS_GATE_EN_0 = 3;
  localparam int MS_CNT0  = 2;
  localparam int MS_MODE0 = 0;
  // Clock select byte
  localparam int CK_SCALE = 0;
  localparam int CK_CLK0  = 2;
  localparam int CK_CLK1  = 3;
  localparam int CK_T2L   = 4;
  localparam int CK_T2H   = 5;
  localparam int CK_T3L   = 6;
  localparam int CK_T3H   = 7;

  localparam int LOW13_BITS = 5;

  localparam logic [5:0] DIV_SYS12 = 6'h0c;
  localparam logic [5:0] DIV_SYS4  = 6'h04;
  localparam logic [5:0] DIV_SYS48 = 6'h30;
  localparam logic [2:0] EXT_LAST  = 3'h7;

  // Synchronised pin vector layout
  localparam int PIN_EV0   = 0;
  localparam int PIN_EV1   = 1;
  localparam int PIN_GT0   = 2;
  localparam int PIN_GT1   = 3;
  localparam int PIN_XCLK  = 4;
  localparam int PIN_COUNT = 5;

  typedef enum logic [1:0] {DLCT_MODE13, DLCT_MODE16, DLCT_RELOAD8, DLCT_SPLIT} dlct_mode_t;
  typedef enum logic [1:0] {DLCT_PS_DIV12, DLCT_PS_DIV4, DLCT_PS_DIV48, DLCT_PS_EXT8} dlct_prescale_t;
  typedef enum logic [1:0] {DLCT_SRC_DIV12, DLCT_SRC_EXT8, DLCT_SRC_SYS} dlct_src_t;

endpackage

// ===== verilog/dlct_prescaler.sv
`timescale 1ns/100ps
module dlct_prescaler
  import dlct_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  dlct_tick_if.src  tick
);
  typedef struct packed {
    logic [5:0] div_cnt;
    logic [2:0] ext_cnt;
    logic       tick;
  } dlct_presc_t;

  dlct_presc_t state_reg;
  dlct_presc_t state_next;
  logic [5:0]  lim;

  always_comb begin
    state_next = state_reg;
    unique case (tick.prescale_field) // RQ17
      DLCT_PS_DIV12: lim = DIV_SYS12;
      DLCT_PS_DIV4:  lim = DIV_SYS4;
      DLCT_PS_DIV48: lim = DIV_SYS48;
      DLCT_PS_EXT8:  lim = DIV_SYS12;
    endcase
    if (state_reg.div_cnt >= lim - 6'h01) begin
      state_next.div_cnt = '0;
    end else begin
      state_next.div_cnt = state_reg.div_cnt + 6'h01;
    end
    if (tick.ext_rise) begin
      state_next.ext_cnt = state_reg.ext_cnt + 3'h1; // RQ18
    end
    if (tick.prescale_field == DLCT_PS_EXT8) begin
      state_next.tick = tick.ext_rise && (state_reg.ext_cnt == EXT_LAST); // RQ18
    end else begin
      state_next.tick = (state_reg.div_cnt >= lim - 6'h01);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick.presc_tick = state_reg.tick;

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_div4_period: assert property ( // RQ17
    (tick.presc_tick && tick.prescale_field == DLCT_PS_DIV4) ##1 (tick.prescale_field == DLCT_PS_DIV4)[*4]
      |-> tick.presc_tick)
    else $error("Divide-by-4 tick period wrong");
endmodule

// ===== verilog/dlct_tick_if.sv
`timescale 1ns/100ps
interface dlct_tick_if;
  import dlct_pkg::*;
  dlct_prescale_t prescale_field;
  logic           ext_rise;
  logic           presc_tick;
  modport src (input prescale_field, input ext_rise, output presc_tick);
  modport snk (output prescale_field, output ext_rise, input presc_tick);
endinterface

// ===== verilog/dlct_timers.sv
`timescale 1ns/100ps
module dlct_timers
  import dlct_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       event_pin_0,
  input  wire logic       event_pin_1,
  input  wire logic       ext_gate_in_0,
  input  wire logic       ext_gate_in_1,
  input  wire logic       gate_polarity_0,
  input  wire logic       gate_polarity_1,
  input  wire logic       ext_osc_clk,
  input  wire logic       t2_split,
  input  wire logic       t3_split,
  input  wire logic       t2_extclk_sel,
  input  wire logic       t3_extclk_sel,
  input  wire logic       ovf_vector_ack_0,
  input  wire logic       ovf_vector_ack_1,
  input  wire logic       ext_vector_ack_0,
  input  wire logic       ext_vector_ack_1,
  output logic            ovf_flag_0,
  output logic            ovf_flag_1,
  output logic            ext_irq_flag_0,
  output logic            ext_irq_flag_1,
  output logic            unit1_ovf_pulse,
  output dlct_src_t       t2_low_src,
  output dlct_src_t       t2_high_src,
  output dlct_src_t       t3_low_src,
  output dlct_src_t       t3_high_src
);
  typedef struct packed {
    logic [7:0] ctrl_status;
    logic [7:0] mode_sel;
    logic [7:0] clk_sel;
    logic [7:0] u0_lo;
    logic [7:0] u0_hi;
    logic [7:0] u1_lo;
    logic [7:0] u1_hi;
    logic [7:0] rdata;
    logic       u1_pulse;
    dlct_src_t  t2l;
    dlct_src_t  t2h;
    dlct_src_t  t3l;
    dlct_src_t  t3h;
  } dlct_state_t;

  dlct_state_t          state_reg;
  dlct_state_t          state_next;
  logic [PIN_COUNT-1:0] pin_lvl;
  logic [PIN_COUNT-1:0] pin_fall;
  logic [PIN_COUNT-1:0] pin_rise;
  dlct_mode_t           mode0;
  dlct_mode_t           mode1;
  logic                 split;
  logic                 act0;
  logic                 act1;
  logic                 en0;
  logic                 en1;
  logic                 adv0;
  logic                 adv1;
  logic                 adv0h;
  logic [16:0]          r0;
  logic [16:0]          r1;
  logic [8:0]           h0;
  logic                 ovf_set0;
  logic                 ovf_set1;
  logic                 xedge0;
  logic                 xedge1;
  logic [7:0]           cs;

  dlct_tick_if tick_bus ();

  dlct_pin_sync #(
    .W (PIN_COUNT)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  ({ext_osc_clk, ext_gate_in_1, ext_gate_in_0, event_pin_1, event_pin_0}),
    .level   (pin_lvl),
    .fall    (pin_fall),
    .rise    (pin_rise)
  );

  dlct_prescaler u_presc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tick    (tick_bus.src)
  );

  assign tick_bus.prescale_field = dlct_prescale_t'(state_reg.clk_sel[CK_SCALE +: 2]);
  assign tick_bus.ext_rise       = pin_rise[PIN_XCLK];

  ////////////////////////////////////////////////////////////////
  // One count step, returns {overflow, high, low}
  function automatic logic [16:0] step(dlct_mode_t m, logic [7:0] lo, logic [7:0] hi, logic adv);
    logic [13:0] s13;
    logic [16:0] s16;
    s13 = {1'b0, hi, lo[LOW13_BITS-1:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    step = {1'b0, hi, lo};
    if (adv) begin
      unique case (m) // RQ14
        DLCT_MODE13:  step = {s13[13], s13[12:LOW13_BITS], lo[7:LOW13_BITS], s13[LOW13_BITS-1:0]}; // RQ4
        DLCT_MODE16:  step = s16; // RQ5
        DLCT_RELOAD8: step = (lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01}; // RQ6
        DLCT_SPLIT:   step = {lo == 8'hff, hi, lo + 8'h01}; // RQ7
      endcase
    end
  endfunction

  function automatic dlct_src_t src_of(logic sys_sel, logic xclk);
    src_of = sys_sel ? DLCT_SRC_SYS : (xclk ? DLCT_SRC_EXT8 : DLCT_SRC_DIV12);
  endfunction

  ////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    mode0  = dlct_mode_t'(state_reg.mode_sel[MS_MODE0 +: 2]); // RQ14
    mode1  = dlct_mode_t'(state_reg.mode_sel[MS_MODE1 +: 2]);
    split  = (mode0 == DLCT_SPLIT);
    act0   = (pin_lvl[PIN_GT0] == gate_polarity_0);
    act1   = (pin_lvl[PIN_GT1] == gate_polarity_1);
    xedge0 = gate_polarity_0 ? pin_rise[PIN_GT0] : pin_fall[PIN_GT0];
    xedge1 = gate_polarity_1 ? pin_rise[PIN_GT1] : pin_fall[PIN_GT1];
    en0    = state_reg.ctrl_status[CS_RUN0] && (!state_reg.mode_sel[MS_GATE_EN_0] || act0); // RQ1
    // Unit 1 run follows its mode while unit 0 is split
    if (split) begin
      en1 = (mode1 != DLCT_SPLIT); // RQ10
    end else begin
      en1 = state_reg.ctrl_status[CS_RUN1] && (!state_reg.mode_sel[MS_GATE_EN_1] || act1)
            && (mode1 != DLCT_SPLIT); // RQ3
    end
    // Pin edge when counting (unit 1 only while not split), else system or prescaled clock
    adv0 = en0 && (state_reg.mode_sel[MS_CNT0] ? pin_fall[PIN_EV0]
                   : (state_reg.clk_sel[CK_CLK0] || tick_bus.presc_tick)); // RQ15 RQ16
    adv1 = en1 && ((state_reg.mode_sel[MS_CNT1] && !split) ? pin_fall[PIN_EV1]
                   : (state_reg.clk_sel[CK_CLK1] || tick_bus.presc_tick)); // RQ9 RQ3
    adv0h = split && state_reg.ctrl_status[CS_RUN1]
            && (state_reg.clk_sel[CK_CLK0] || tick_bus.presc_tick); // RQ7
    r0 = step(mode0, state_reg.u0_lo, state_reg.u0_hi, adv0);
    r1 = step(mode1, state_reg.u1_lo, state_reg.u1_hi, adv1);
    h0 = {1'b0, state_reg.u0_hi} + {8'h00, adv0h};
    ovf_set0 = r0[16];
    ovf_set1 = split ? (adv0h && h0[8]) : r1[16]; // RQ8 RQ9
    state_next.u1_pulse = r1[16]; // RQ9
    state_next.u0_lo = r0[7:0];
    state_next.u0_hi = split ? h0[7:0] : r0[15:8];
    state_next.u1_lo = r1[7:0];
    state_next.u1_hi = r1[15:8];

    // Software writes land as written, except level-type external flags; hardware sets still win
    cs = state_reg.ctrl_status;
    cs[CS_OVF0] = cs[CS_OVF0] && !ovf_vector_ack_0; // RQ11
    cs[CS_OVF1] = cs[CS_OVF1] && !ovf_vector_ack_1; // RQ11
    cs[CS_XF0]  = cs[CS_XF0] && !ext_vector_ack_0;
    cs[CS_XF1]  = cs[CS_XF1] && !ext_vector_ack_1;
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_CTRL_STATUS: cs = sfr_wdata; // RQ2
        ADDR_MODE_SEL:    state_next.mode_sel = sfr_wdata;
        ADDR_CLK_SEL:     state_next.clk_sel = sfr_wdata;
        ADDR_U0_LO:       state_next.u0_lo = sfr_wdata;
        ADDR_U0_HI:       state_next.u0_hi = sfr_wdata;
        ADDR_U1_LO:       state_next.u1_lo = sfr_wdata;
        ADDR_U1_HI:       state_next.u1_hi = sfr_wdata;
        default:          ;
      endcase
    end
    cs[CS_OVF0] = cs[CS_OVF0] || ovf_set0; // RQ11
    cs[CS_OVF1] = cs[CS_OVF1] || ovf_set1; // RQ11
    // Level type follows the input, edge type latches
    cs[CS_XF0] = state_reg.ctrl_status[CS_XT0] ? (cs[CS_XF0] || xedge0) : act0; // RQ12 RQ13
    cs[CS_XF1] = state_reg.ctrl_status[CS_XT1] ? (cs[CS_XF1] || xedge1) : act1; // RQ12 RQ13
    state_next.ctrl_status = cs;

    unique case (sfr_addr)
      ADDR_CTRL_STATUS: state_next.rdata = state_reg.ctrl_status;
      ADDR_MODE_SEL:    state_next.rdata = state_reg.mode_sel;
      ADDR_CLK_SEL:     state_next.rdata = state_reg.clk_sel;
      ADDR_U0_LO:       state_next.rdata = state_reg.u0_lo;
      ADDR_U0_HI:       state_next.rdata = state_reg.u0_hi;
      ADDR_U1_LO:       state_next.rdata = state_reg.u1_lo;
      ADDR_U1_HI:       state_next.rdata = state_reg.u1_hi;
      default:          state_next.rdata = RST_BYTE;
    endcase

    // Whole-timer clock is the low select; high select only when split
    state_next.t2l = src_of(state_reg.clk_sel[CK_T2L], t2_extclk_sel); // RQ20
    state_next.t3l = src_of(state_reg.clk_sel[CK_T3L], t3_extclk_sel); // RQ20
    state_next.t2h = t2_split ? src_of(state_reg.clk_sel[CK_T2H], t2_extclk_sel) : state_next.t2l; // RQ19
    state_next.t3h = t3_split ? src_of(state_reg.clk_sel[CK_T3H], t3_extclk_sel) : state_next.t3l; // RQ19
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sfr_rdata       = state_reg.rdata;
  assign ovf_flag_0      = state_reg.ctrl_status[CS_OVF0];
  assign ovf_flag_1      = state_reg.ctrl_status[CS_OVF1];
  assign ext_irq_flag_0  = state_reg.ctrl_status[CS_XF0];
  assign ext_irq_flag_1  = state_reg.ctrl_status[CS_XF1];
  assign unit1_ovf_pulse = state_reg.u1_pulse;
  assign t2_low_src      = state_reg.t2l;
  assign t2_high_src     = state_reg.t2h;
  assign t3_low_src      = state_reg.t3l;
  assign t3_high_src     = state_reg.t3h;

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_gate_hold_count: assert property ( // RQ1
    (!split && state_reg.ctrl_status[CS_RUN0] && state_reg.mode_sel[MS_GATE_EN_0] && !act0 && !sfr_wr)
      |=> $stable({state_reg.u0_hi, state_reg.u0_lo}))
    else $error("Unit 0 counted while gated off");

  a_run_no_load: assert property ( // RQ2
    (sfr_wr && sfr_addr == ADDR_CTRL_STATUS && !state_reg.ctrl_status[CS_RUN0] && !split)
      |=> $stable({state_reg.u0_hi, state_reg.u0_lo}))
    else $error("Run write disturbed unit 0 count");

  a_mode13_wrap: assert property ( // RQ4
    (mode0 == DLCT_MODE13 && adv0 && state_reg.u0_hi == 8'hff && state_reg.u0_lo[4:0] == 5'h1f && !sfr_wr)
      |=> (ovf_flag_0 && state_reg.u0_hi == 8'h00 && state_reg.u0_lo[4:0] == 5'h00))
    else $error("13-bit wrap wrong");

  a_mode16_step: assert property ( // RQ5 RQ15
    (mode0 == DLCT_MODE16 && state_reg.mode_sel[MS_CNT0] && en0 && pin_fall[PIN_EV0] && !sfr_wr)
      |=> {state_reg.u0_hi, state_reg.u0_lo} == 16'($past({state_reg.u0_hi, state_reg.u0_lo}) + 16'h0001))
    else $error("16-bit pin count did not step");

  a_reload_low: assert property ( // RQ6
    (mode1 == DLCT_RELOAD8 && adv1 && state_reg.u1_lo == 8'hff && !sfr_wr)
      |=> (state_reg.u1_lo == $past(state_reg.u1_hi) && $stable(state_reg.u1_hi)))
    else $error("Auto-reload failed");

  a_split_high_ovf: assert property ( // RQ8
    (adv0h && state_reg.u0_hi == 8'hff && !sfr_wr) |=> (ovf_flag_1 && state_reg.u0_hi == 8'h00))
    else $error("Split high overflow lost");

  a_unit1_no_flag: assert property ( // RQ9
    (split && !ovf_flag_1 && !(adv0h && state_reg.u0_hi == 8'hff) && !sfr_wr) |=> !ovf_flag_1)
    else $error("Unit 1 set its flag while unit 0 split");

  a_unit1_mode3_stop: assert property ( // RQ10
    (split && mode1 == DLCT_SPLIT && !sfr_wr) |=> $stable({state_reg.u1_hi, state_reg.u1_lo}))
    else $error("Unit 1 ran in mode 3");

  a_vector_clear: assert property ( // RQ11
    (ovf_vector_ack_0 && ovf_flag_0 && !ovf_set0 && !sfr_wr) |=> !ovf_flag_0)
    else $error("Vectoring did not clear overflow flag");

  a_level_irq: assert property ( // RQ12
    (!state_reg.ctrl_status[CS_XT0] && !sfr_wr) |=> (ext_irq_flag_0 == $past(act0)))
    else $error("Level flag does not follow input");

  c_split_overflow: cover property (adv0h && state_reg.u0_hi == 8'hff);
  c_reload: cover property (mode0 == DLCT_RELOAD8 && ovf_set0);
  c_pin_count: cover property (state_reg.mode_sel[MS_CNT0] && adv0);
  c_edge_irq: cover property (state_reg.ctrl_status[CS_XT1] && xedge1);
endmodule
